/* rtl/axcfg_defs.svh */
// offsets, field positions, reset values and limits of the exposure loop register bank
`ifndef AXCFG_DEFS_SVH
`define AXCFG_DEFS_SVH

// ------------------------------------------------------------
// addressing
// ------------------------------------------------------------
`define AXCFG_ADDR_W        8
`define AXCFG_DATA_W        16
`define AXCFG_BASE          8'ha0
`define AXCFG_OFS_CTRL      8'h00
`define AXCFG_OFS_TARGET    8'h01
`define AXCFG_OFS_RED       8'h02
`define AXCFG_OFS_GREEN1    8'h03
`define AXCFG_OFS_GREEN2    8'h04
`define AXCFG_OFS_BLUE      8'h05
`define AXCFG_OFS_MIN_EXP   8'h08
`define AXCFG_OFS_MAX_EXP   8'h0a
`define AXCFG_OFS_PIX_LO    8'h18
`define AXCFG_OFS_PIX_HI    8'h19

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define AXCFG_CTRL_W        5
`define AXCFG_BIT_ENABLE    0
`define AXCFG_BIT_RESTART   1
`define AXCFG_BIT_FREEZE    2
`define AXCFG_BIT_SUBSAMPLE 3
`define AXCFG_BIT_PRIORITY  4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define AXCFG_RST_CTRL      5'h10
`define AXCFG_RST_TARGET    16'h60b8
`define AXCFG_RST_WEIGHT    10'h080
`define AXCFG_RST_MIN_EXP   16'h0001
`define AXCFG_RST_MAX_EXP   16'h03ff

// ------------------------------------------------------------
// field widths and datapath
// ------------------------------------------------------------
`define AXCFG_TARGET_W      10
`define AXCFG_WEIGHT_W      10
`define AXCFG_WEIGHT_FRAC   7
`define AXCFG_PIX_W         10
`define AXCFG_COUNT_W       19
`define AXCFG_SUM_W         32
`define AXCFG_SUBSAMPLE_N   2'h3

`endif

/* rtl/axcfg_pkg.sv */
// types of the exposure loop register bank
package axcfg_pkg;

    typedef enum logic [1:0] {
        AXCFG_RED,
        AXCFG_GREEN1,
        AXCFG_GREEN2,
        AXCFG_BLUE
    } axcfg_color_t;

    typedef enum {
        ST_IDLE,
        ST_ACCUM,
        ST_UPDATE
    } axcfg_state_t;

endpackage : axcfg_pkg

/* rtl/axcfg_field_reg.sv */
// one writable register field with its own reset value
`timescale 1ns/10ps

module axcfg_field_reg #(
    parameter int          W   = 16,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // write side
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // stored value
    output logic      [W-1:0] q
);

    initial begin
        if (W < 1 || W > 16) begin
            $error("axcfg_field_reg: width out of range");
        end
    end

    logic [W-1:0] q_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= RST;
        end else if (wr_en) begin
            q_reg <= wr_data;
        end
    end

    assign q = q_reg;

endmodule : axcfg_field_reg

/* rtl/axcfg_regs.sv */
// exposure loop configuration registers with statistics and loop filter
//
// What this block does
// - freeze holds filter state and stage gains
// - subsample bit uses every pixel or every 4th
// - priority one favours stage 1, zero stage 2
// - 10-bit target intensity, reset 184
// - red weight 3.7 unsigned, reset unity
// - green1, green2, blue weights 3.7, reset unity
// - exposure pulled within min and max limits at each loop update while enabled and not frozen
// - read-only 19-bit sampled pixel count, two registers
`timescale 1ns/10ps
`include "axcfg_defs.svh"

module axcfg_regs #(
    parameter int         STAGE1_MAX = 1,
    parameter int         STAGE2_MAX = 3
) (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    // configuration port
    input  wire logic [`AXCFG_ADDR_W-1:0]      cfg_addr,
    input  wire logic                          cfg_wr,
    input  wire logic [`AXCFG_DATA_W-1:0]      cfg_wdata,
    input  wire logic                          cfg_rd,
    output logic      [`AXCFG_DATA_W-1:0]      cfg_rdata,
    output logic                               cfg_rvalid,
    // pixel statistics input
    input  wire logic                          pix_valid,
    input  wire logic [`AXCFG_PIX_W-1:0]       pix_data,
    input  wire axcfg_pkg::axcfg_color_t       pix_color,
    input  wire logic                          frame_end,
    // loop results
    output logic      [`AXCFG_DATA_W-1:0]      exposure,
    output logic      [1:0]                    gain_stage1,
    output logic      [1:0]                    gain_stage2,
    output logic                               loop_active
);
    import axcfg_pkg::*;

    initial begin
        if (STAGE1_MAX < 0 || STAGE1_MAX > 3 || STAGE2_MAX < 0 || STAGE2_MAX > 3) begin
            $error("axcfg_regs: stage gain limit out of range");
        end
    end

    localparam logic [1:0] S1_MAX = 2'(STAGE1_MAX);
    localparam logic [1:0] S2_MAX = 2'(STAGE2_MAX);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic [`AXCFG_ADDR_W-1:0] ofs       = cfg_addr - `AXCFG_BASE;
    wire logic                     in_block  = cfg_addr >= `AXCFG_BASE;
    wire logic                     wr_ctrl   = cfg_wr && in_block && ofs == `AXCFG_OFS_CTRL;
    wire logic                     wr_target = cfg_wr && in_block && ofs == `AXCFG_OFS_TARGET;
    wire logic                     wr_red    = cfg_wr && in_block && ofs == `AXCFG_OFS_RED;
    wire logic                     wr_green1 = cfg_wr && in_block && ofs == `AXCFG_OFS_GREEN1;
    wire logic                     wr_green2 = cfg_wr && in_block && ofs == `AXCFG_OFS_GREEN2;
    wire logic                     wr_blue   = cfg_wr && in_block && ofs == `AXCFG_OFS_BLUE;
    wire logic                     wr_min    = cfg_wr && in_block && ofs == `AXCFG_OFS_MIN_EXP;
    wire logic                     wr_max    = cfg_wr && in_block && ofs == `AXCFG_OFS_MAX_EXP;

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    logic [`AXCFG_CTRL_W-1:0]   ctrl_q;
    logic [`AXCFG_DATA_W-1:0]   target_q;
    logic [`AXCFG_WEIGHT_W-1:0] red_q;
    logic [`AXCFG_WEIGHT_W-1:0] green1_q;
    logic [`AXCFG_WEIGHT_W-1:0] green2_q;
    logic [`AXCFG_WEIGHT_W-1:0] blue_q;
    logic [`AXCFG_DATA_W-1:0]   min_exp_q;
    logic [`AXCFG_DATA_W-1:0]   max_exp_q;

    axcfg_field_reg #(.W(`AXCFG_CTRL_W), .RST(`AXCFG_RST_CTRL)) u_ctrl (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_ctrl),
        .wr_data(cfg_wdata[`AXCFG_CTRL_W-1:0]), .q(ctrl_q)
    );
    axcfg_field_reg #(.W(`AXCFG_DATA_W), .RST(`AXCFG_RST_TARGET)) u_target (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_target), .wr_data(cfg_wdata), .q(target_q)
    );
    axcfg_field_reg #(.W(`AXCFG_WEIGHT_W), .RST(`AXCFG_RST_WEIGHT)) u_red (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_red),
        .wr_data(cfg_wdata[`AXCFG_WEIGHT_W-1:0]), .q(red_q)
    );
    axcfg_field_reg #(.W(`AXCFG_WEIGHT_W), .RST(`AXCFG_RST_WEIGHT)) u_green1 (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_green1),
        .wr_data(cfg_wdata[`AXCFG_WEIGHT_W-1:0]), .q(green1_q)
    );
    axcfg_field_reg #(.W(`AXCFG_WEIGHT_W), .RST(`AXCFG_RST_WEIGHT)) u_green2 (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_green2),
        .wr_data(cfg_wdata[`AXCFG_WEIGHT_W-1:0]), .q(green2_q)
    );
    axcfg_field_reg #(.W(`AXCFG_WEIGHT_W), .RST(`AXCFG_RST_WEIGHT)) u_blue (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_blue),
        .wr_data(cfg_wdata[`AXCFG_WEIGHT_W-1:0]), .q(blue_q)
    );
    axcfg_field_reg #(.W(`AXCFG_DATA_W), .RST(`AXCFG_RST_MIN_EXP)) u_min (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_min), .wr_data(cfg_wdata), .q(min_exp_q)
    );
    axcfg_field_reg #(.W(`AXCFG_DATA_W), .RST(`AXCFG_RST_MAX_EXP)) u_max (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_max), .wr_data(cfg_wdata), .q(max_exp_q)
    );

    wire logic enable_bit  = ctrl_q[`AXCFG_BIT_ENABLE];
    wire logic freeze_bit  = ctrl_q[`AXCFG_BIT_FREEZE];
    wire logic subsamp_bit = ctrl_q[`AXCFG_BIT_SUBSAMPLE];
    wire logic stage1_pri  = ctrl_q[`AXCFG_BIT_PRIORITY];
    // restart acts on the write itself
    wire logic restart     = wr_ctrl && cfg_wdata[`AXCFG_BIT_RESTART];
    wire logic [`AXCFG_TARGET_W-1:0] target = target_q[`AXCFG_TARGET_W-1:0];

    // ------------------------------------------------------------
    // statistics path
    // ------------------------------------------------------------
    axcfg_state_t state_reg, state_next;
    logic [1:0]                 sub_cnt_reg;
    logic [`AXCFG_SUM_W-1:0]    sum_reg;
    logic [`AXCFG_COUNT_W-1:0]  cnt_reg;
    logic [`AXCFG_COUNT_W-1:0]  total_reg;
    logic                       bright_reg;

    // every 4th pixel when subsampling
    wire logic take_pix = pix_valid && (!subsamp_bit || sub_cnt_reg == 2'h0);
    wire logic [`AXCFG_WEIGHT_W-1:0] weight =
        pix_color == AXCFG_RED    ? red_q    :
        pix_color == AXCFG_GREEN1 ? green1_q :
        pix_color == AXCFG_GREEN2 ? green2_q : blue_q;
    wire logic [`AXCFG_PIX_W+`AXCFG_WEIGHT_W-1:0] product = pix_data * weight;
    wire logic [`AXCFG_SUM_W-1:0] weighted =
        `AXCFG_SUM_W'(product[`AXCFG_PIX_W+`AXCFG_WEIGHT_W-1:`AXCFG_WEIGHT_FRAC]);
    // widen both operands so the product keeps all of its bits
    wire logic [`AXCFG_SUM_W-1:0] goal = `AXCFG_SUM_W'(target) * `AXCFG_SUM_W'(cnt_reg);
    wire logic cnt_full = &cnt_reg;
    wire logic run      = enable_bit && !freeze_bit;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:   if (enable_bit) begin
                state_next = ST_ACCUM;
            end
            ST_ACCUM:  if (!enable_bit) begin
                state_next = ST_IDLE;
            end else if (frame_end) begin
                state_next = ST_UPDATE;
            end
            ST_UPDATE: state_next = ST_ACCUM;
            default:   state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= ST_IDLE;
            sub_cnt_reg <= 2'h0;
            sum_reg     <= '0;
            cnt_reg     <= '0;
        end else begin
            state_reg <= restart ? ST_IDLE : state_next;
            if (state_reg != ST_ACCUM || restart) begin
                sub_cnt_reg <= 2'h0;
                sum_reg     <= '0;
                cnt_reg     <= '0;
            end else if (pix_valid) begin
                sub_cnt_reg <= sub_cnt_reg == `AXCFG_SUBSAMPLE_N ? 2'h0 : sub_cnt_reg + 2'h1;
                if (take_pix && !cnt_full) begin
                    sum_reg <= sum_reg + weighted;
                    cnt_reg <= cnt_reg + `AXCFG_COUNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            total_reg  <= '0;
            bright_reg <= 1'b0;
        end else if (state_reg == ST_ACCUM && frame_end && enable_bit) begin
            total_reg  <= cnt_reg;
            bright_reg <= sum_reg > goal;
        end
    end

    // ------------------------------------------------------------
    // loop filter: raise exposure before gains, shed gains before exposure, stages by priority
    // ------------------------------------------------------------
    logic [`AXCFG_DATA_W-1:0] exp_reg, exp_next;
    logic [1:0]               g1_reg, g1_next, g2_reg, g2_next;
    logic                     active_reg;

    wire logic too_dark = !bright_reg;
    wire logic g1_up    = g1_reg < S1_MAX;
    wire logic g2_up    = g2_reg < S2_MAX;

    always_comb begin
        exp_next = exp_reg;
        g1_next  = g1_reg;
        g2_next  = g2_reg;
        if (exp_reg < min_exp_q) begin
            exp_next = min_exp_q;
        end else if (exp_reg > max_exp_q) begin
            exp_next = max_exp_q;
        end else if (too_dark) begin
            if (exp_reg < max_exp_q) begin
                exp_next = exp_reg + 16'h0001;
            end else if (stage1_pri ? g1_up : !g2_up && g1_up) begin
                g1_next = g1_reg + 2'h1;
            end else if (g2_up) begin
                g2_next = g2_reg + 2'h1;
            end
        end else begin
            // shed the less favoured stage first
            if (stage1_pri ? g2_reg != 2'h0 : g1_reg == 2'h0 && g2_reg != 2'h0) begin
                g2_next = g2_reg - 2'h1;
            end else if (g1_reg != 2'h0) begin
                g1_next = g1_reg - 2'h1;
            end else if (exp_reg > min_exp_q) begin
                exp_next = exp_reg - 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            exp_reg    <= `AXCFG_RST_MIN_EXP;
            g1_reg     <= 2'h0;
            g2_reg     <= 2'h0;
            active_reg <= 1'b0;
        end else begin
            active_reg <= enable_bit;
            if (restart) begin
                exp_reg <= min_exp_q;
                g1_reg  <= 2'h0;
                g2_reg  <= 2'h0;
            end else if (state_reg == ST_UPDATE && run) begin
                exp_reg <= exp_next;
                g1_reg  <= g1_next;
                g2_reg  <= g2_next;
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [`AXCFG_DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (in_block) begin
            case (ofs)
                `AXCFG_OFS_CTRL:    rd_mux = `AXCFG_DATA_W'(ctrl_q);
                `AXCFG_OFS_TARGET:  rd_mux = target_q;
                `AXCFG_OFS_RED:     rd_mux = `AXCFG_DATA_W'(red_q);
                `AXCFG_OFS_GREEN1:  rd_mux = `AXCFG_DATA_W'(green1_q);
                `AXCFG_OFS_GREEN2:  rd_mux = `AXCFG_DATA_W'(green2_q);
                `AXCFG_OFS_BLUE:    rd_mux = `AXCFG_DATA_W'(blue_q);
                `AXCFG_OFS_MIN_EXP: rd_mux = min_exp_q;
                `AXCFG_OFS_MAX_EXP: rd_mux = max_exp_q;
                `AXCFG_OFS_PIX_LO:  rd_mux = total_reg[15:0];
                `AXCFG_OFS_PIX_HI:  rd_mux = `AXCFG_DATA_W'(total_reg[`AXCFG_COUNT_W-1:16]);
                default:            rd_mux = '0;
            endcase
        end
    end

    logic [`AXCFG_DATA_W-1:0] rdata_reg;
    logic                     rvalid_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= cfg_rd;
            if (cfg_rd) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign cfg_rdata   = rdata_reg;
    assign cfg_rvalid  = rvalid_reg;
    assign exposure    = exp_reg;
    assign gain_stage1 = g1_reg;
    assign gain_stage2 = g2_reg;
    assign loop_active = active_reg;

endmodule : axcfg_regs

/* testbench/axcfg_regs_sva.sv */
// assertion checker of the exposure loop register bank
`timescale 1ns/10ps
`include "axcfg_defs.svh"

module axcfg_chk (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // configuration port
    input wire logic [7:0]  cfg_addr,
    input wire logic        cfg_wr,
    input wire logic [15:0] cfg_wdata,
    input wire logic        cfg_rd,
    input wire logic [15:0] cfg_rdata,
    input wire logic        cfg_rvalid,
    // loop results
    input wire logic [15:0] exposure,
    input wire logic [1:0]  gain_stage1,
    input wire logic [1:0]  gain_stage2,
    input wire logic        loop_active
);
    // ------------------------------------------------------------
    // shadow of the writable registers
    // ------------------------------------------------------------
    logic [4:0]  ctrl_reg;
    logic [15:0] tgt_reg;
    logic [15:0] min_reg;
    logic [15:0] max_reg;
    logic [9:0]  wt_reg [4];
    logic [15:0] rd_next;
    logic [1:0]  wsel;
    logic        wr_ctrl;

    assign wsel    = cfg_addr[1:0] - 2'h2;
    assign wr_ctrl = cfg_wr && cfg_addr == 8'ha0;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `AXCFG_RST_CTRL;
            tgt_reg  <= `AXCFG_RST_TARGET;
            min_reg  <= `AXCFG_RST_MIN_EXP;
            max_reg  <= `AXCFG_RST_MAX_EXP;
            wt_reg   <= '{default: `AXCFG_RST_WEIGHT};
        end else if (cfg_wr) begin
            case (cfg_addr)
                8'ha0: ctrl_reg <= cfg_wdata[4:0];
                8'ha1: tgt_reg <= cfg_wdata;
                8'ha2, 8'ha3, 8'ha4, 8'ha5: wt_reg[wsel] <= cfg_wdata[9:0];
                8'ha8: min_reg <= cfg_wdata;
                8'haa: max_reg <= cfg_wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (cfg_addr)
            8'ha0: rd_next = {11'h0, ctrl_reg};
            8'ha1: rd_next = tgt_reg;
            8'ha2, 8'ha3, 8'ha4, 8'ha5: rd_next = {6'h0, wt_reg[wsel]};
            8'ha8: rd_next = min_reg;
            8'haa: rd_next = max_reg;
            default: rd_next = 16'h0;
        endcase
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_read_answer: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read strobe without valid");
    a_rvalid_cause: assert property (cfg_rvalid |-> $past(cfg_rd))
        else $error("valid without read strobe");
    a_read_value: assert property (cfg_rd && cfg_addr[7:1] != 7'h5c |=> cfg_rdata == $past(rd_next))
        else $error("read data differs from register");
    a_count_upper_zero: assert property (cfg_rd && cfg_addr == 8'hb9 |=> cfg_rdata[15:3] == 13'h0)
        else $error("count upper bits not zero");
    a_loop_follows_enable: assert property (wr_ctrl ##1 !wr_ctrl |=> loop_active == $past(cfg_wdata[0], 2))
        else $error("loop active not following enable");
    a_freeze_holds_outputs: assert property (ctrl_reg[2] && !wr_ctrl |=>
        $stable(exposure) && $stable(gain_stage1) && $stable(gain_stage2))
        else $error("outputs moved while frozen");
    a_idle_holds_outputs: assert property (!ctrl_reg[0] && !wr_ctrl |=>
        $stable(exposure) && $stable(gain_stage1) && $stable(gain_stage2))
        else $error("outputs moved while disabled");
    a_restart_loads_min: assert property (wr_ctrl && cfg_wdata[1] |=>
        exposure == min_reg && gain_stage1 == 2'h0 && gain_stage2 == 2'h0)
        else $error("restart did not reload loop");
    a_exposure_within_limits: assert property (!cfg_wr |=>
        $stable(exposure) || (exposure >= min_reg && exposure <= max_reg))
        else $error("exposure outside limits");
endmodule : axcfg_chk

bind axcfg_regs axcfg_chk axcfg_chk_inst (.mclk(mclk), .rst_n(rst_n), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .exposure(exposure), .gain_stage1(gain_stage1),
    .gain_stage2(gain_stage2), .loop_active(loop_active));

/* testbench/test_axcfg_regs.sv */
// self-checking bench of the exposure loop register bank
`timescale 1ns/10ps

module test_axcfg_regs;
    import axcfg_pkg::*;
    logic         mclk;
    logic         rst_n;
    logic [7:0]   cfg_addr;
    logic         cfg_wr;
    logic [15:0]  cfg_wdata;
    logic         cfg_rd;
    logic [15:0]  cfg_rdata;
    logic         cfg_rvalid;
    logic         pix_valid;
    logic [9:0]   pix_data;
    axcfg_color_t pix_color;
    logic         frame_end;
    logic [15:0]  exposure;
    logic [1:0]   gain_stage1;
    logic [1:0]   gain_stage2;
    logic         loop_active;
    int           failures;
    int           checks;

    axcfg_regs axcfg_regs_inst (.mclk(mclk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .pix_valid(pix_valid), .pix_data(pix_data), .pix_color(pix_color), .frame_end(frame_end),
        .exposure(exposure), .gain_stage1(gain_stage1), .gain_stage2(gain_stage2),
        .loop_active(loop_active));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        cfg_wr    <= 1'b1;
        cfg_addr  <= a;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        cfg_rd   <= 1'b1;
        cfg_addr <= a;
        @(posedge mclk);
        cfg_rd <= 1'b0;
        #1;
        check({15'h0, cfg_rvalid}, 16'h1);
        check(cfg_rdata, e);
    endtask : rd

    // expected code: exposure in upper nibble, then stage 1 and stage 2 gains
    task automatic outs(input logic [7:0] c);
        check(exposure, {12'h0, c[7:4]});
        check({12'h0, gain_stage1, gain_stage2}, {12'h0, c[3:0]});
    endtask : outs

    // n pixels of value v, colours cycling, then frame close and update
    task automatic frame(input int n, input logic [9:0] v);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            pix_valid <= 1'b1;
            pix_data  <= v;
            pix_color <= axcfg_color_t'(i[1:0]);
        end
        @(posedge mclk);
        pix_valid <= 1'b0;
        frame_end <= 1'b1;
        @(posedge mclk);
        frame_end <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : frame

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        stop_test();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        cfg_addr = 8'h0;
        cfg_wr = 1'b0;
        cfg_wdata = 16'h0;
        cfg_rd = 1'b0;
        pix_valid = 1'b0;
        pix_data = 10'h0;
        pix_color = AXCFG_RED;
        frame_end = 1'b0;
        failures = 0;
        checks = 0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'ha0, 16'h0010);
        rd(8'ha1, 16'h60b8);
        rd(8'ha2, 16'h0080);
        for (int i = 3; i < 6; i++) begin
            rd(8'ha0 + 8'(i), 16'h0080);
        end
        rd(8'ha8, 16'h0001);
        rd(8'haa, 16'h03ff);
        rd(8'hb8, 16'h0000);
        rd(8'hb9, 16'h0000);
        wr(8'ha2, 16'hffff);
        rd(8'ha2, 16'h03ff);
        wr(8'ha2, 16'h0080);
        wr(8'ha1, 16'hffff);
        rd(8'ha1, 16'hffff);
        wr(8'ha1, 16'h00b8);
        wr(8'hb9, 16'hffff);
        rd(8'hb9, 16'h0000);
        wr(8'h9f, 16'h1234);
        rd(8'h9f, 16'h0000);
        wr(8'haa, 16'h0003);
        wr(8'ha0, 16'h0011);
        @(posedge mclk);
        #1;
        check({15'h0, loop_active}, 16'h1);
        frame(8, 10'h0);
        outs(8'h20);
        frame(8, 10'h0);
        outs(8'h30);
        frame(8, 10'h0);
        outs(8'h34);
        frame(8, 10'h0);
        outs(8'h35);
        rd(8'hb8, 16'h0008);
        wr(8'ha0, 16'h0015);
        frame(8, 10'h0);
        outs(8'h35);
        rd(8'hb8, 16'h0008);
        wr(8'ha0, 16'h0019);
        frame(8, 10'h3ff);
        outs(8'h34);
        rd(8'hb8, 16'h0002);
        wr(8'ha0, 16'h0001);
        frame(8, 10'h3ff);
        outs(8'h30);
        frame(8, 10'h3ff);
        outs(8'h20);
        wr(8'ha1, 16'd100);
        for (int c = 0; c < 4; c++) begin
            wr(8'ha2 + 8'(c), 16'hfd00);
            rd(8'ha2 + 8'(c), 16'h0100);
            frame(4, 10'd100);
            outs(8'h10);
            wr(8'ha2 + 8'(c), 16'h0080);
            frame(4, 10'd100);
            outs(8'h20);
        end
        wr(8'ha8, 16'h0003);
        frame(4, 10'd100);
        outs(8'h30);
        wr(8'ha8, 16'h0001);
        wr(8'haa, 16'h0002);
        frame(4, 10'd100);
        outs(8'h20);
        wr(8'ha0, 16'h0013);
        #1;
        outs(8'h10);
        rd(8'ha0, 16'h0013);
        wr(8'ha0, 16'h0010);
        repeat (2) @(posedge mclk);
        #1;
        check({15'h0, loop_active}, 16'h0);
        frame(8, 10'h0);
        outs(8'h10);
        stop_test();
    end
endmodule : test_axcfg_regs
